// ### rtl/indirect_switch_memory_access.sv
// indirect access controller for control and data memories
// assumes an APB master on mclk_in and a reference clock pin
`timescale 1ns/1ps
`default_nettype none
module indirect_switch_memory_access (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic reference_clock_in,
  input wire logic pcm_rx_valid_in,
  input wire logic [6:0] pcm_rx_slot_in,
  input wire logic [7:0] pcm_rx_data_in,
  input wire logic [6:0] pcm_tx_slot_in,
  input wire logic cfi_wr_valid_in,
  input wire logic [6:0] cfi_wr_slot_in,
  input wire logic [7:0] cfi_wr_data_in,
  input wire logic [7:0] cfi_wr_mask_in,
  output logic [7:0] pcm_tx_data_out,
  output logic [3:0] pcm_tx_drive_out,
  output logic interfaces_on_out
);
  typedef struct packed {
    mem_access_pkg::state_t st;
    mem_access_pkg::op_t op;
    logic [7:0] data;
    logic [7:0] addr;
    logic [7:0] cmd;
    logic [7:0] mode;
    logic [11:0] half;
    logic [11:0] tgt;
    logic [2:0] rsync;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] tx_data;
    logic [3:0] tx_drive;
    logic if_on;
    logic [255:0][3:0] cm_code;
    logic [255:0][7:0] cm_data;
    logic [127:0][7:0] dm_up;
    logic [127:0][7:0] dm_dn;
    logic [127:0][3:0] tri_f;
  } state_s_t;

  state_s_t s_q;
  state_s_t s_d;
  logic [1:0] mode_sel;
  logic hedge;
  logic setup;
  logic wr_acc;
  logic launch;
  logic done;
  logic [6:0] slot;
  logic [7:0] mask;

  // ***************************************************************
  // combinational next state
  // ***************************************************************
  always_comb
  begin
    s_d = s_q;
    mode_sel = {s_q.mode[mem_access_pkg::MODE_SEL_HI],
                s_q.mode[mem_access_pkg::MODE_SEL_LO]};
    hedge = s_q.rsync[2] ^ s_q.rsync[1];
    setup = psel_in && !penable_in && !s_q.pready;
    wr_acc = psel_in && penable_in && s_q.pready && pwrite_in;
    launch = 1'b0;
    done = 1'b0;
    slot = mem_access_pkg::slot_map(mode_sel, s_q.addr[6:0]);
    mask = mem_access_pkg::moc_mask(
      s_q.cmd[mem_access_pkg::CMD_MOC_HI:mem_access_pkg::CMD_MOC_LO]);
    s_d.rsync = {s_q.rsync[1:0], reference_clock_in};
    // apb slave: one wait-free access phase after each setup
    s_d.pready = setup;
    s_d.pslverr = 1'b0;
    if (setup)
    begin
      s_d.prdata = 32'h0;
      if (paddr_in[4:0] == mem_access_pkg::OFF_DATA)
      begin
        s_d.prdata = {24'h0, s_q.data};
      end
      else if (paddr_in[4:0] == mem_access_pkg::OFF_ADDR)
      begin
        s_d.prdata = {24'h0, s_q.addr};
      end
      else if (paddr_in[4:0] == mem_access_pkg::OFF_CMD)
      begin
        s_d.prdata = {24'h0, s_q.cmd};
      end
      else if (paddr_in[4:0] == mem_access_pkg::OFF_STATUS)
      begin
        s_d.prdata[mem_access_pkg::STATUS_PEND] =
          (s_q.st == mem_access_pkg::ST_RUN);
      end
      else if (paddr_in[4:0] == mem_access_pkg::OFF_MODE)
      begin
        s_d.prdata = {24'h0, s_q.mode};
      end
      else
      begin
        s_d.pslverr = 1'b1;
      end
      if (paddr_in[31:5] != 27'h0)
      begin
        s_d.pslverr = 1'b1;
        s_d.prdata = 32'h0;
      end
    end
    // register writes; access registers are locked while busy
    if (wr_acc && paddr_in[31:5] == 27'h0)
    begin
      if (paddr_in[4:0] == mem_access_pkg::OFF_MODE)
      begin
        s_d.mode = pwdata_in[7:0];
      end
      else if (s_q.st == mem_access_pkg::ST_IDLE)
      begin
        if (paddr_in[4:0] == mem_access_pkg::OFF_DATA)
        begin
          s_d.data = pwdata_in[7:0];
        end
        else if (paddr_in[4:0] == mem_access_pkg::OFF_ADDR)
        begin
          s_d.addr = pwdata_in[7:0];
        end
        else if (paddr_in[4:0] == mem_access_pkg::OFF_CMD)
        begin
          s_d.cmd = pwdata_in[7:0];
          launch = 1'b1;
        end
      end
    end
    // ***************************************************************
    // access sequencer
    // ***************************************************************
    case (s_q.st)
      mem_access_pkg::ST_IDLE:
      begin
        if (launch)
        begin
          s_d.st = mem_access_pkg::ST_RUN;
          if (mode_sel == mem_access_pkg::MODE_CM_RESET)
          begin
            s_d.op = mem_access_pkg::OP_CM_RST;
          end
          else if (pwdata_in[mem_access_pkg::CMD_RWS])
          begin
            s_d.op = mem_access_pkg::OP_DM_RD;
          end
          else if (pwdata_in[2:0] != 3'h0)
          begin
            s_d.op = mem_access_pkg::OP_NOP;
          end
          else if (pwdata_in[6:3] == mem_access_pkg::MOC_TRI_ONE)
          begin
            s_d.op = mem_access_pkg::OP_TRI_WR;
          end
          else if (pwdata_in[6:3] == mem_access_pkg::MOC_TRI_ALL)
          begin
            s_d.op = mem_access_pkg::OP_TRI_ALL;
          end
          else
          begin
            s_d.op = mem_access_pkg::OP_DM_WR;
          end
          if (mode_sel == mem_access_pkg::MODE_CM_RESET)
          begin
            s_d.tgt = mem_access_pkg::CMRST_HALF;
          end
          else if (mode_sel == mem_access_pkg::MODE_TEST ||
                   (!pwdata_in[mem_access_pkg::CMD_RWS] &&
                    pwdata_in[6:0] == {mem_access_pkg::MOC_TRI_ALL, 3'h0}))
          begin
            s_d.tgt = mem_access_pkg::SWEEP_HALF;
          end
          else if (mode_sel == mem_access_pkg::MODE_CM_INIT)
          begin
            s_d.tgt = mem_access_pkg::INIT_HALF;
          end
          else
          begin
            s_d.tgt = mem_access_pkg::NORM_HALF;
          end
          s_d.half = 12'h0;
        end
      end
      mem_access_pkg::ST_RUN:
      begin
        if (hedge)
        begin
          s_d.half = s_q.half + 12'h1;
          done = (s_q.half + 12'h1 == s_q.tgt);
        end
        if (done)
        begin
          s_d.st = mem_access_pkg::ST_IDLE;
          case (s_q.op)
            mem_access_pkg::OP_DM_RD:
            begin
              if (mode_sel == mem_access_pkg::MODE_TEST)
              begin
                s_d.data = s_q.dm_up[0];
              end
              else if (s_q.addr[mem_access_pkg::ADDR_UP])
              begin
                s_d.data = s_q.dm_up[slot];
              end
              else
              begin
                s_d.data = s_q.dm_dn[slot];
              end
            end
            mem_access_pkg::OP_DM_WR:
            begin
              for (int i = 0; i < 128; i++)
              begin
                if (mode_sel == mem_access_pkg::MODE_TEST ||
                    i[6:0] == slot)
                begin
                  s_d.dm_up[i] = (s_q.dm_up[i] & ~mask) |
                                 (s_q.data & mask);
                end
              end
            end
            mem_access_pkg::OP_TRI_WR, mem_access_pkg::OP_TRI_ALL:
            begin
              for (int i = 0; i < 128; i++)
              begin
                if (s_q.op == mem_access_pkg::OP_TRI_ALL ||
                    mode_sel == mem_access_pkg::MODE_TEST ||
                    i[6:0] == slot)
                begin
                  s_d.tri_f[i] = s_q.data[3:0];
                end
              end
            end
            mem_access_pkg::OP_CM_RST:
            begin
              for (int i = 0; i < 256; i++)
              begin
                s_d.cm_data[i] = s_q.data;
                s_d.cm_code[i] = mem_access_pkg::CM_CODE_UNASSIGNED;
              end
            end
            default:
            begin
              s_d.op = s_q.op;
            end
          endcase
        end
      end
      default:
      begin
        s_d.st = mem_access_pkg::ST_IDLE;
      end
    endcase
    // ***************************************************************
    // serial interface side
    // ***************************************************************
    s_d.if_on = (mode_sel == mem_access_pkg::MODE_NORMAL ||
                 mode_sel == mem_access_pkg::MODE_TEST);
    if (s_q.if_on && pcm_rx_valid_in)
    begin
      s_d.dm_dn[pcm_rx_slot_in] = pcm_rx_data_in;
    end
    if (s_q.if_on && cfi_wr_valid_in)
    begin
      s_d.dm_up[cfi_wr_slot_in] =
        (s_d.dm_up[cfi_wr_slot_in] & ~cfi_wr_mask_in) |
        (cfi_wr_data_in & cfi_wr_mask_in);
    end
    // stored upstream value goes out every frame in normal and test modes only
    s_d.tx_data = s_q.if_on ? s_q.dm_up[pcm_tx_slot_in] : 8'h00;
    s_d.tx_drive = s_q.if_on ? s_q.tri_f[pcm_tx_slot_in] : 4'h0;
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      s_q <= '0;
      s_q.st <= mem_access_pkg::ST_IDLE;
      s_q.op <= mem_access_pkg::OP_NOP;
      s_q.mode <= mem_access_pkg::MODE_RESET_VAL;
      s_q.data <= mem_access_pkg::BYTE_RESET_VAL;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pready_out = s_q.pready;
  assign prdata_out = s_q.prdata;
  assign pslverr_out = s_q.pslverr;
  assign pcm_tx_data_out = s_q.tx_data;
  assign pcm_tx_drive_out = s_q.tx_drive;
  assign interfaces_on_out = s_q.if_on;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  a_cmd_launch: assert property (launch |=> s_q.st ==
    mem_access_pkg::ST_RUN) else $error("command did not start access");
  a_busy_lock: assert property ((s_q.st == mem_access_pkg::ST_RUN)
    |=> $stable(s_q.addr) && $stable(s_q.cmd))
    else $error("access registers changed while busy");
  a_pend_clear: assert property (done |=> s_q.st ==
    mem_access_pkg::ST_IDLE) else $error("pending not cleared");
  a_norm_time: assert property (launch && mode_sel ==
    mem_access_pkg::MODE_NORMAL && s_d.tgt != mem_access_pkg::SWEEP_HALF
    |=> s_q.tgt == 12'd19) else $error("normal access time wrong");
  a_init_time: assert property (launch && mode_sel ==
    mem_access_pkg::MODE_CM_INIT && s_d.tgt != mem_access_pkg::SWEEP_HALF
    |=> s_q.tgt == 12'd5) else $error("init access time wrong");
  a_reset_fill: assert property (done && s_q.op ==
    mem_access_pkg::OP_CM_RST |=> s_q.cm_code[255] == 4'h0 &&
    s_q.cm_data[0] == $past(s_q.data) && s_q.tgt == 12'd512)
    else $error("control memory reset wrong");
  a_if_off: assert property ((mode_sel == 2'h0 ||
    mode_sel == 2'h2) |=> !interfaces_on_out)
    else $error("interfaces active in reset or init");
  a_half_bound: assert property (s_q.st == mem_access_pkg::ST_RUN
    |-> s_q.half < s_q.tgt) else $error("half count overran");
  a_rd_data: assert property (done && s_q.op == mem_access_pkg::OP_DM_RD
    && mode_sel != mem_access_pkg::MODE_TEST && !s_q.addr[7]
    |=> s_q.data == $past(s_q.dm_dn[slot]))
    else $error("read data not full byte");
  a_up_write: assert property (done && s_q.op == mem_access_pkg::OP_DM_WR
    && mode_sel != mem_access_pkg::MODE_TEST && !cfi_wr_valid_in
    |=> (s_q.dm_up[$past(slot)] & $past(mask)) ==
        ($past(s_q.data) & $past(mask)))
    else $error("upstream write missed");

  c_read: cover property (done && s_q.op == mem_access_pkg::OP_DM_RD);
  c_write: cover property (done && s_q.op == mem_access_pkg::OP_DM_WR);
  c_reset: cover property (done && s_q.op == mem_access_pkg::OP_CM_RST);
endmodule // indirect_switch_memory_access
`default_nettype wire

// ### rtl/mem_access_pkg.sv
// constants and types for the indirect switch memory access block
// assumes a 100 MHz system clock and a slower reference clock pin
`default_nettype none
package mem_access_pkg;
  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [4:0] OFF_DATA = 5'h00;
  localparam logic [4:0] OFF_ADDR = 5'h04;
  localparam logic [4:0] OFF_CMD = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0c;
  localparam logic [4:0] OFF_MODE = 5'h10;
  localparam logic [7:0] MODE_RESET_VAL = 8'h00;
  localparam logic [7:0] BYTE_RESET_VAL = 8'h00;
  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int MODE_SEL_HI = 7;
  localparam int MODE_SEL_LO = 6;
  localparam int CMD_RWS = 7;
  localparam int CMD_MOC_HI = 6;
  localparam int CMD_MOC_LO = 3;
  localparam int ADDR_UP = 7;
  localparam int STATUS_PEND = 0;
  // ***************************************************************
  // mode and operation codes
  // ***************************************************************
  localparam logic [1:0] MODE_CM_RESET = 2'h0;
  localparam logic [1:0] MODE_TEST = 2'h1;
  localparam logic [1:0] MODE_CM_INIT = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  localparam logic [3:0] MOC_NONE = 4'h0;
  localparam logic [3:0] MOC_TRI_ONE = 4'hc;
  localparam logic [3:0] MOC_TRI_ALL = 4'hd;
  localparam logic [3:0] CM_CODE_UNASSIGNED = 4'h0;
  // ***************************************************************
  // access times in tenths of reference cycles, then half periods
  // ***************************************************************
  localparam int NORM_TENTHS = 95;
  localparam int INIT_TENTHS = 25;
  localparam int CMRST_TENTHS = 2560;
  localparam int SWEEP_TENTHS = 10350;
  localparam logic [11:0] NORM_HALF = 12'(NORM_TENTHS * 2 / 10);
  localparam logic [11:0] INIT_HALF = 12'(INIT_TENTHS * 2 / 10);
  localparam logic [11:0] CMRST_HALF = 12'(CMRST_TENTHS * 2 / 10);
  localparam logic [11:0] SWEEP_HALF = 12'(SWEEP_TENTHS * 2 / 10);
  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } state_t;
  typedef enum logic [5:0] {
    OP_DM_RD = 6'b000001,
    OP_DM_WR = 6'b000010,
    OP_TRI_WR = 6'b000100,
    OP_TRI_ALL = 6'b001000,
    OP_CM_RST = 6'b010000,
    OP_NOP = 6'b100000
  } op_t;
  // port and timeslot lookup, identity until the slot layout is fixed
  function automatic logic [6:0] slot_map(input logic [1:0] mode,
                                          input logic [6:0] addr);
    slot_map = (mode == MODE_TEST) ? addr : addr;
  endfunction
  // sub-timeslot mask selected by the operation code
  function automatic logic [7:0] moc_mask(input logic [3:0] moc);
    case (moc)
      4'h1: moc_mask = 8'hff;
      4'h3: moc_mask = 8'hf0;
      4'h2: moc_mask = 8'h0f;
      4'h7: moc_mask = 8'hc0;
      4'h6: moc_mask = 8'h30;
      4'h5: moc_mask = 8'h0c;
      4'h4: moc_mask = 8'h03;
      default: moc_mask = 8'h00;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### sim/indirect_switch_memory_access_tb_top.sv
// apb driven bench for the indirect memory access block
// assumes the pcm far end model and the design package
`timescale 1ns/1ps
`default_nettype none
module indirect_switch_memory_access_tb_top;
  // ***************************************************************
  // signals and instances
  // ***************************************************************
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] paddr_in = 32'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic cfi_wr_valid_in = 1'b0;
  logic [6:0] cfi_wr_slot_in = 7'h00;
  logic [7:0] cfi_wr_data_in = 8'h00;
  logic [7:0] cfi_wr_mask_in = 8'h00;
  logic pready_out, pslverr_out, reference_clock_in, pcm_rx_valid_in;
  logic interfaces_on_out;
  logic [31:0] prdata_out;
  logic [6:0] pcm_rx_slot_in, pcm_tx_slot_in;
  logic [7:0] pcm_rx_data_in, pcm_tx_data_out;
  logic [3:0] pcm_tx_drive_out;
  logic [31:0] rd_v;
  logic err_v;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h7, 4'h6, 4'h5, 4'h4};
  logic [7:0] masks [8] = '{8'h00, 8'hff, 8'hf0, 8'h0f, 8'hc0, 8'h30,
                            8'h0c, 8'h03};
  always #5 mclk_in = ~mclk_in;
  indirect_switch_memory_access DUT (.mclk_in(mclk_in), .srst_in(srst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .reference_clock_in(reference_clock_in),
    .pcm_rx_valid_in(pcm_rx_valid_in), .pcm_rx_slot_in(pcm_rx_slot_in),
    .pcm_rx_data_in(pcm_rx_data_in), .pcm_tx_slot_in(pcm_tx_slot_in),
    .cfi_wr_valid_in(cfi_wr_valid_in), .cfi_wr_slot_in(cfi_wr_slot_in),
    .cfi_wr_data_in(cfi_wr_data_in), .cfi_wr_mask_in(cfi_wr_mask_in),
    .pcm_tx_data_out(pcm_tx_data_out), .pcm_tx_drive_out(pcm_tx_drive_out),
    .interfaces_on_out(interfaces_on_out));
  pcm_far_end_model far_end (.mclk_in(mclk_in), .srst_in(srst_in),
    .pcm_tx_data_in(pcm_tx_data_out),
    .reference_clock_out(reference_clock_in),
    .pcm_rx_valid_out(pcm_rx_valid_in), .pcm_rx_slot_out(pcm_rx_slot_in),
    .pcm_rx_data_out(pcm_rx_data_in), .pcm_tx_slot_out(pcm_tx_slot_in));
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [4:0] off,
                     input logic [7:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= {27'h0, off};
    pwdata_in <= {24'h0, d};
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // wait for pready; only the bench timeout ends a hung wait
    do
    begin
      @(posedge mclk_in);
    end
    while (pready_out !== 1'b1);
    rd_v = prdata_out;
    err_v = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1)
      check(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [4:0] off, input logic [7:0] d);
    apb(1'b1, off, d);
  endtask
  task automatic rd_chk(input logic [4:0] off, input logic [7:0] exp);
    apb(1'b0, off, 8'h00);
    check(rd_v, {24'h0, exp});
  endtask
  // launch, see pending, poke data while busy when max is over 40, poll, bound the time
  task automatic mem_cmd(input logic [7:0] cmd, input int max);
    int t0;
    wr(mem_access_pkg::OFF_CMD, cmd);
    t0 = cycles;
    apb(1'b0, mem_access_pkg::OFF_STATUS, 8'h00);
    check(rd_v & 32'h1, 32'h1);
    if (max > 40)
      wr(mem_access_pkg::OFF_DATA, 8'hee);
    do
    begin
      apb(1'b0, mem_access_pkg::OFF_STATUS, 8'h00);
    end
    while (rd_v[0] !== 1'b0);
    check({31'h0, (cycles - t0) <= max}, 32'h1);
  endtask
  task automatic settle_on(input logic exp);
    repeat (3) @(posedge mclk_in);
    check({31'h0, interfaces_on_out}, {31'h0, exp});
  endtask
  // ***************************************************************
  // timeout and main sequence
  // ***************************************************************
  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      err_count = err_count + 1;
      finish_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge mclk_in);
    srst_in <= 1'b0;
    rd_chk(mem_access_pkg::OFF_MODE, 8'h00);
    settle_on(1'b0);
    apb(1'b0, 5'h14, 8'h00);
    check({31'h0, err_v}, 32'h1);
    check(rd_v, 32'h0);
    wr(mem_access_pkg::OFF_DATA, 8'h3c);
    mem_cmd(8'h70, 1040);
    settle_on(1'b0);
    wr(mem_access_pkg::OFF_MODE, 8'h80);
    settle_on(1'b0);
    mem_cmd(8'h01, 26);
    wr(mem_access_pkg::OFF_MODE, 8'hc5);
    rd_chk(mem_access_pkg::OFF_MODE, 8'hc5);
    settle_on(1'b1);
    wr(mem_access_pkg::OFF_DATA, 8'ha5);
    wr(mem_access_pkg::OFF_ADDR, 8'h05);
    mem_cmd(8'h08, 54);
    rd_chk(mem_access_pkg::OFF_DATA, 8'ha5);
    repeat (300) @(posedge mclk_in);
    check({24'h0, far_end.tx_seen[5]}, 32'ha5);
    wr(mem_access_pkg::OFF_ADDR, 8'h85);
    mem_cmd(8'h80, 54);
    rd_chk(mem_access_pkg::OFF_DATA, 8'ha5);
    wr(mem_access_pkg::OFF_ADDR, 8'h05);
    mem_cmd(8'h80, 54);
    rd_chk(mem_access_pkg::OFF_DATA, 8'h05 ^ 8'h5a);
    for (int i = 0; i < 8; i++)
    begin
      wr(mem_access_pkg::OFF_DATA, 8'h00);
      wr(mem_access_pkg::OFF_ADDR, 8'(16 + i));
      mem_cmd(8'h08, 54);
      wr(mem_access_pkg::OFF_DATA, 8'hff);
      mem_cmd({1'b0, codes[i], 3'h0}, 54);
      wr(mem_access_pkg::OFF_ADDR, 8'(8'h90 + i));
      mem_cmd({1'b1, codes[i], 3'h0}, 54);
      rd_chk(mem_access_pkg::OFF_DATA, masks[i]);
    end
    wr(mem_access_pkg::OFF_DATA, 8'h06);
    wr(mem_access_pkg::OFF_ADDR, 8'h1e);
    mem_cmd(8'h10, 54);
    @(posedge mclk_in);
    cfi_wr_valid_in <= 1'b1;
    cfi_wr_slot_in <= 7'h1e;
    cfi_wr_data_in <= 8'ha0;
    cfi_wr_mask_in <= 8'hf0;
    @(posedge mclk_in);
    cfi_wr_valid_in <= 1'b0;
    wr(mem_access_pkg::OFF_ADDR, 8'h9e);
    mem_cmd(8'h80, 54);
    rd_chk(mem_access_pkg::OFF_DATA, 8'ha6);
    wr(mem_access_pkg::OFF_MODE, 8'h40);
    settle_on(1'b1);
    wr(mem_access_pkg::OFF_DATA, 8'h77);
    wr(mem_access_pkg::OFF_ADDR, 8'h05);
    mem_cmd(8'h08, 4156);
    wr(mem_access_pkg::OFF_MODE, 8'hc0);
    wr(mem_access_pkg::OFF_ADDR, 8'he4);
    mem_cmd(8'h80, 54);
    rd_chk(mem_access_pkg::OFF_DATA, 8'h77);
    wr(mem_access_pkg::OFF_DATA, 8'h0f);
    mem_cmd(8'h68, 4156);
    repeat (3) @(posedge mclk_in);
    check({28'h0, pcm_tx_drive_out}, 32'hf);
    finish_test();
  end
endmodule // indirect_switch_memory_access_tb_top
`default_nettype wire

// ### sim/pcm_far_end_model.sv
// far end of the pcm side: reference clock, receive stream, tx capture
// assumes the bench supplies mclk_in and srst_in
`timescale 1ns/1ps
`default_nettype none
module pcm_far_end_model (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [7:0] pcm_tx_data_in,
  output logic reference_clock_out,
  output logic pcm_rx_valid_out,
  output logic [6:0] pcm_rx_slot_out,
  output logic [7:0] pcm_rx_data_out,
  output logic [6:0] pcm_tx_slot_out
);
  // ***************************************************************
  // slot sweep, one slot per cycle, reference clock at mclk / 4
  // ***************************************************************
  logic [1:0] div_q;
  logic [6:0] prev_slot_q;
  logic [7:0] tx_seen [128];
  // received byte is a fixed function of its slot
  assign pcm_rx_data_out = {1'b0, pcm_rx_slot_out} ^ 8'h5a;
  assign reference_clock_out = div_q[1];
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      div_q <= 2'h0;
      pcm_rx_valid_out <= 1'b0;
      pcm_rx_slot_out <= 7'h00;
      pcm_tx_slot_out <= 7'h00;
      prev_slot_q <= 7'h00;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      pcm_rx_valid_out <= 1'b1;
      pcm_rx_slot_out <= pcm_rx_slot_out + 7'h01;
      pcm_tx_slot_out <= pcm_tx_slot_out + 7'h01;
      prev_slot_q <= pcm_tx_slot_out;
      tx_seen[prev_slot_q] <= pcm_tx_data_in;
    end
  end
endmodule // pcm_far_end_model
`default_nettype wire
